// File: verilog/erx_pkg.sv
// Package with register map, field layout and reset values of the receive interrupt block.
package erx_pkg;

  // ****************************************************************
  // Register indices and count
  // ****************************************************************
  localparam int NREG           = 25;       // Stored registers; the status register is extra.
  localparam int IDX_TX_OK      = 0;
  localparam int IDX_SCOL       = 1;
  localparam int IDX_MCOL       = 2;
  localparam int IDX_RX_OK      = 3;
  localparam int IDX_FCS        = 4;
  localparam int IDX_ALIGN      = 5;
  localparam int IDX_CFG_ONE    = 6;
  localparam int IDX_CFG_TWO    = 7;
  localparam int IDX_B2B_GAP    = 8;
  localparam int IDX_NB2B_GAP   = 9;
  localparam int IDX_COLL_RETRY = 10;
  localparam int IDX_MAX_FRAME  = 11;
  localparam int IDX_PHY_SUPP   = 12;
  localparam int IDX_MAC_TEST   = 13;
  localparam int IDX_MGMT_CFG   = 14;
  localparam int IDX_MGMT_CMD   = 15;
  localparam int IDX_MGMT_ADDR  = 16;
  localparam int IDX_CTRL       = 17;
  localparam int IDX_RX_FILTER  = 18;
  localparam int IDX_WATERMARK  = 19;
  localparam int IDX_PMM_LOW    = 20;
  localparam int IDX_PMM_HIGH   = 21;
  localparam int IDX_IRQ_REQ    = 22;
  localparam int IDX_EVT_STAT   = 23;
  localparam int IDX_EVT_MASK   = 24;
  localparam int IDX_STATUS     = 25;       // Computed, no aliases.
  localparam int NSTAT          = 6;        // Statistics counters at indices 0 to 5.

  // ****************************************************************
  // Byte offsets of the base registers (aliases at +0x4, +0x8, +0xC)
  // ****************************************************************
  localparam logic [NREG:0][13:0] OFS = '{
    IDX_TX_OK: 14'h2110, IDX_SCOL: 14'h2120, IDX_MCOL: 14'h2130, IDX_RX_OK: 14'h2140,
    IDX_FCS: 14'h2150, IDX_ALIGN: 14'h2160, IDX_CFG_ONE: 14'h2200, IDX_CFG_TWO: 14'h2210,
    IDX_B2B_GAP: 14'h2220, IDX_NB2B_GAP: 14'h2230, IDX_COLL_RETRY: 14'h2240,
    IDX_MAX_FRAME: 14'h2250, IDX_PHY_SUPP: 14'h2260, IDX_MAC_TEST: 14'h2270,
    IDX_MGMT_CFG: 14'h2280, IDX_MGMT_CMD: 14'h2290, IDX_MGMT_ADDR: 14'h22A0,
    IDX_CTRL: 14'h2000, IDX_RX_FILTER: 14'h2010, IDX_WATERMARK: 14'h2020,
    IDX_PMM_LOW: 14'h2030, IDX_PMM_HIGH: 14'h2040, IDX_IRQ_REQ: 14'h2050,
    IDX_EVT_STAT: 14'h2060, IDX_EVT_MASK: 14'h2070, IDX_STATUS: 14'h2080};

  // ****************************************************************
  // Implemented bits and reset values
  // ****************************************************************
  localparam logic [NREG-1:0][31:0] WMASK = '{
    IDX_TX_OK: 32'h0000FFFF, IDX_SCOL: 32'h0000FFFF, IDX_MCOL: 32'h0000FFFF,
    IDX_RX_OK: 32'h0000FFFF, IDX_FCS: 32'h0000FFFF, IDX_ALIGN: 32'h0000FFFF,
    IDX_CFG_ONE: 32'h0000CF1F, IDX_CFG_TWO: 32'h000073FF, IDX_B2B_GAP: 32'h0000007F,
    IDX_NB2B_GAP: 32'h00007F7F, IDX_COLL_RETRY: 32'h00003F0F, IDX_MAX_FRAME: 32'h0000FFFF,
    IDX_PHY_SUPP: 32'h00001900, IDX_MAC_TEST: 32'h00000007, IDX_MGMT_CFG: 32'h0000803F,
    IDX_MGMT_CMD: 32'h00000003, IDX_MGMT_ADDR: 32'h00001F1F, IDX_CTRL: 32'h00000100,
    IDX_RX_FILTER: 32'h00000F00, IDX_WATERMARK: 32'h00FF00FF, IDX_PMM_LOW: 32'hFFFFFFFF,
    IDX_PMM_HIGH: 32'hFFFFFFFF, IDX_IRQ_REQ: 32'h00006300, IDX_EVT_STAT: 32'h0000000F,
    IDX_EVT_MASK: 32'h0000000F};
  localparam logic [NREG-1:0][31:0] RESET_VAL = '{
    IDX_CFG_ONE: 32'h0000800D, IDX_CFG_TWO: 32'h00004082, IDX_B2B_GAP: 32'h00000012,
    IDX_NB2B_GAP: 32'h00000C12, IDX_COLL_RETRY: 32'h0000370F, IDX_MAX_FRAME: 32'h000005EE,
    IDX_PHY_SUPP: 32'h00001000, IDX_MGMT_CFG: 32'h00000020, IDX_MGMT_ADDR: 32'h00000100,
    default: 32'h00000000};

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_TX_BUS_ERR   = 14;
  localparam int BIT_RX_BUS_ERR   = 13;
  localparam int BIT_EMPTY_WM     = 9;
  localparam int BIT_FULL_WM      = 8;
  localparam int BIT_RX_ENABLE    = 8;
  localparam int BIT_CNT_DEC      = 0;
  localparam int LSB_PM_MODE      = 8;
  localparam int LSB_EMPTY_LVL    = 0;
  localparam int LSB_FULL_LVL     = 16;
  localparam int LSB_BUF_COUNT    = 16;
  localparam int EVT_TX_BUS_ERR   = 0;
  localparam int EVT_RX_BUS_ERR   = 1;
  localparam int EVT_EMPTY_WM     = 2;
  localparam int EVT_FULL_WM      = 3;

  // Alias selector taken from address bits 3:2.
  localparam logic [1:0] OP_BASE = 2'h0;
  localparam logic [1:0] OP_CLR  = 2'h1;
  localparam logic [1:0] OP_SET  = 2'h2;
  localparam logic [1:0] OP_INV  = 2'h3;

  // Whole state of the block.
  typedef struct packed {
    logic                   ack;
    logic [31:0]            rdata;
    logic [7:0]             buf_count;
    logic [NREG-1:0][31:0]  regs;
  } erx_state_t;

endpackage

// File: verilog/erx_irq_mask.sv
// Receive interrupt flags, pattern-match mask and controller register file.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - TX DMA bus error sets bit 14
// - RX DMA bus error sets bit 13
// - Bus-error flags hold until reset or clear
// - Empty watermark flag when count at most level
// - Hardware count increment clears empty watermark flag
// - Full watermark flag when count at least level
// - Only decrement-bit write clears full watermark flag
// - Interrupt request register writes never change watermark flags
// - 64-bit pattern mask, two registers, reset zero
// - Clear, set, invert aliases at plus 4, 8, C
// - Unimplemented bits read zero, ignore writes
// - Accept 16/32-bit accesses, ignore 8-bit accesses

module erx_irq_mask (
  input  wire  logic        ref_clk_i,                // System clock, 200 MHz.
  input  wire  logic        srst_i,                   // Synchronous reset, active high.
  input  wire  logic [13:0] avs_address_i,            // Byte address.
  input  wire  logic        avs_read_i,               // Read request.
  input  wire  logic        avs_write_i,              // Write request.
  input  wire  logic [3:0]  avs_byteenable_i,         // Byte lanes.
  input  wire  logic [31:0] avs_writedata_i,          // Write data.
  output logic [31:0]       avs_readdata_o,           // Read data, registered.
  output logic              avs_waitrequest_o,        // Stall until the answer.
  input  wire  logic        tx_dma_bus_error_i,       // TX DMA bus error pulse.
  input  wire  logic        rx_dma_bus_error_i,       // RX DMA bus error pulse.
  input  wire  logic        rx_buffer_count_inc_i,    // Hardware adds one descriptor.
  input  wire  logic [5:0]  stat_event_i,             // One increment per counter.
  output logic              receive_enable_o,         // Receive enable bit.
  output logic [3:0]        pattern_match_mode_o,     // Pattern-match mode field.
  output logic [63:0]       pattern_match_mask_o,     // Receive pattern-match mask.
  output logic [7:0]        rx_descriptor_buffer_count_o, // Buffer count.
  output logic [3:0]        irq_flags_o,              // Flags 14, 13, 9, 8.
  output logic              irq_o                     // Level interrupt.
);

  // ****************************************************************
  // State and decode signals
  // ****************************************************************
  erx_pkg::erx_state_t st;
  erx_pkg::erx_state_t next_st;
  logic        req;
  logic [13:0] base_addr;
  logic [1:0]  op;
  logic [5:0]  idx;
  logic        hit;
  logic        size_ok;
  logic [31:0] bem;
  logic [31:0] wbits;
  logic        wr;
  logic        rd_take;
  logic        dec;
  logic        empty_now;
  logic        full_now;
  logic [3:0]  evt_set;
  logic [31:0] irq_applied;

  // Finds the register whose base offset matches; returns NREG+1 on a miss.
  function automatic logic [5:0] find_idx(input logic [13:0] a);
    logic [5:0] r;
    r = 6'(erx_pkg::NREG + 1);
    for (int i = 0; i <= erx_pkg::NREG; i++) begin
      if (erx_pkg::OFS[i] == a) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction

  // Expands byte enables into a bit mask.
  function automatic logic [31:0] lanes(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{be[b]}};
    end
    return m;
  endfunction

  // Applies a base, clear, set or invert write to an old value.
  function automatic logic [31:0] apply_op(input logic [1:0] o, input logic [31:0] old,
                                           input logic [31:0] wd, input logic [31:0] m);
    logic [31:0] r;
    r = old;
    case (o)
      erx_pkg::OP_BASE: r = (old & ~m) | (wd & m);
      erx_pkg::OP_CLR:  r = old & ~(wd & m);
      erx_pkg::OP_SET:  r = old | (wd & m);
      erx_pkg::OP_INV:  r = old ^ (wd & m);
      default:          r = old;
    endcase
    return r;
  endfunction

  // Read view of one register; the status register is built from the count.
  function automatic logic [31:0] read_view(input logic [5:0] i, input erx_pkg::erx_state_t s);
    logic [31:0] r;
    r = '0;
    if (i == 6'(erx_pkg::IDX_STATUS)) begin
      r[erx_pkg::LSB_BUF_COUNT +: 8] = s.buf_count;
    end else if (i < 6'(erx_pkg::NREG)) begin
      r = s.regs[i] & erx_pkg::WMASK[i];
    end
    return r;
  endfunction

  // ****************************************************************
  // Avalon-MM decode
  // ****************************************************************
  // Request decode: aliases share a 16-byte slot, the status register has only its base.
  assign req       = avs_read_i | avs_write_i;
  assign base_addr = {avs_address_i[13:4], 4'h0};
  assign op        = avs_address_i[3:2];
  assign idx       = find_idx(base_addr);
  assign hit       = (idx < 6'(erx_pkg::IDX_STATUS)) ||
                     (idx == 6'(erx_pkg::IDX_STATUS) && op == erx_pkg::OP_BASE);
  assign size_ok   = (avs_byteenable_i == 4'hF) || (avs_byteenable_i == 4'h3) ||
                     (avs_byteenable_i == 4'hC);
  assign bem       = lanes(avs_byteenable_i);
  assign wbits     = avs_writedata_i & bem;

  // Accepted write and event status read; both happen at the edge where waitrequest is low.
  assign wr        = avs_write_i & st.ack & hit & size_ok &
                     (idx < 6'(erx_pkg::NREG)) & (idx != 6'(erx_pkg::IDX_EVT_STAT));
  assign rd_take   = avs_read_i & st.ack & hit & size_ok & (idx == 6'(erx_pkg::IDX_EVT_STAT));

  // Decrement request: a one written to the decrement bit by base, set or invert.
  assign dec = wr && (idx == 6'(erx_pkg::IDX_CTRL)) && (op != erx_pkg::OP_CLR) &&
               wbits[erx_pkg::BIT_CNT_DEC];

  // Watermark comparisons against the current count.
  assign empty_now = st.buf_count <=
                     st.regs[erx_pkg::IDX_WATERMARK][erx_pkg::LSB_EMPTY_LVL +: 8];
  assign full_now  = st.buf_count >=
                     st.regs[erx_pkg::IDX_WATERMARK][erx_pkg::LSB_FULL_LVL +: 8];

  // Alias operation on the interrupt request register, used only for the bus-error bits.
  assign irq_applied = apply_op(op, st.regs[erx_pkg::IDX_IRQ_REQ], avs_writedata_i, bem);

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Computes the whole next state from the bus, the DMA events and the counters.
  always_comb begin
    next_st     = st;
    next_st.ack = req & ~st.ack;

    // Read data is captured in the first cycle of a request; bad accesses read zero.
    if (req && !st.ack) begin
      next_st.rdata = (avs_read_i && hit && size_ok) ? read_view(idx, st) : '0;
    end

    // Plain register writes; unimplemented bits stay zero.
    if (wr && idx != 6'(erx_pkg::IDX_IRQ_REQ)) begin
      next_st.regs[idx] = apply_op(op, st.regs[idx], avs_writedata_i, bem) &
                          erx_pkg::WMASK[idx];
    end

    // The pattern mask is plain storage; software keeps it still while receive uses it.
    // Both halves come out of reset at zero and feed pattern_match_mask_o.

    // Interrupt request writes reach only the bus-error bits; watermark bits ignore them.
    if (wr && idx == 6'(erx_pkg::IDX_IRQ_REQ)) begin
      next_st.regs[erx_pkg::IDX_IRQ_REQ][erx_pkg::BIT_TX_BUS_ERR] =
        irq_applied[erx_pkg::BIT_TX_BUS_ERR];
      next_st.regs[erx_pkg::IDX_IRQ_REQ][erx_pkg::BIT_RX_BUS_ERR] =
        irq_applied[erx_pkg::BIT_RX_BUS_ERR];
    end

    // Bus errors set their flags; a set in the same cycle as a clear wins.
    if (tx_dma_bus_error_i) begin
      next_st.regs[erx_pkg::IDX_IRQ_REQ][erx_pkg::BIT_TX_BUS_ERR] = 1'b1;
    end
    if (rx_dma_bus_error_i) begin
      next_st.regs[erx_pkg::IDX_IRQ_REQ][erx_pkg::BIT_RX_BUS_ERR] = 1'b1;
    end

    // Statistics counters count their events, after any software write.
    for (int i = 0; i < erx_pkg::NSTAT; i++) begin
      if (stat_event_i[i]) begin
        next_st.regs[i][15:0] = next_st.regs[i][15:0] + 16'h0001;
      end
    end

    // Descriptor buffer count: hardware adds, software subtracts; both together cancel.
    case ({rx_buffer_count_inc_i, dec})
      2'b10: begin
        if (st.buf_count != 8'hFF) begin
          next_st.buf_count = st.buf_count + 8'h01;
        end
      end
      2'b01: begin
        if (st.buf_count != 8'h00) begin
          next_st.buf_count = st.buf_count - 8'h01;
        end
      end
      default: next_st.buf_count = st.buf_count;
    endcase

    // Empty watermark flag: set by the level test, cleared by a hardware increment.
    if (rx_buffer_count_inc_i) begin
      next_st.regs[erx_pkg::IDX_IRQ_REQ][erx_pkg::BIT_EMPTY_WM] = 1'b0;
    end else if (empty_now) begin
      next_st.regs[erx_pkg::IDX_IRQ_REQ][erx_pkg::BIT_EMPTY_WM] = 1'b1;
    end

    // Full watermark flag: set by the level test, cleared only by a decrement write.
    if (dec) begin
      next_st.regs[erx_pkg::IDX_IRQ_REQ][erx_pkg::BIT_FULL_WM] = 1'b0;
    end else if (full_now) begin
      next_st.regs[erx_pkg::IDX_IRQ_REQ][erx_pkg::BIT_FULL_WM] = 1'b1;
    end

    // Rising edges of the four flags, taken here so no loop runs through the next state.
    evt_set[erx_pkg::EVT_TX_BUS_ERR] =
      next_st.regs[erx_pkg::IDX_IRQ_REQ][erx_pkg::BIT_TX_BUS_ERR] &
      ~st.regs[erx_pkg::IDX_IRQ_REQ][erx_pkg::BIT_TX_BUS_ERR];
    evt_set[erx_pkg::EVT_RX_BUS_ERR] =
      next_st.regs[erx_pkg::IDX_IRQ_REQ][erx_pkg::BIT_RX_BUS_ERR] &
      ~st.regs[erx_pkg::IDX_IRQ_REQ][erx_pkg::BIT_RX_BUS_ERR];
    evt_set[erx_pkg::EVT_EMPTY_WM] =
      next_st.regs[erx_pkg::IDX_IRQ_REQ][erx_pkg::BIT_EMPTY_WM] &
      ~st.regs[erx_pkg::IDX_IRQ_REQ][erx_pkg::BIT_EMPTY_WM];
    evt_set[erx_pkg::EVT_FULL_WM] =
      next_st.regs[erx_pkg::IDX_IRQ_REQ][erx_pkg::BIT_FULL_WM] &
      ~st.regs[erx_pkg::IDX_IRQ_REQ][erx_pkg::BIT_FULL_WM];

    // Event status: rising flags set sticky bits; a read clears what it returned.
    next_st.regs[erx_pkg::IDX_EVT_STAT] =
      (st.regs[erx_pkg::IDX_EVT_STAT] & ~(rd_take ? st.rdata : 32'h00000000)) |
      {28'h0000000, evt_set};
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Registers the state; reset loads the documented reset values.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st.ack       <= 1'b0;
      st.rdata     <= 32'h00000000;
      st.buf_count <= 8'h00;
      st.regs      <= erx_pkg::RESET_VAL;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Bus answers one cycle after the request is seen.
  assign avs_waitrequest_o = req & ~st.ack;
  assign avs_readdata_o    = st.rdata;

  // Control fields and state driven from registers.
  assign receive_enable_o     = st.regs[erx_pkg::IDX_CTRL][erx_pkg::BIT_RX_ENABLE];
  assign pattern_match_mode_o = st.regs[erx_pkg::IDX_RX_FILTER][erx_pkg::LSB_PM_MODE +: 4];
  assign pattern_match_mask_o = {st.regs[erx_pkg::IDX_PMM_HIGH], st.regs[erx_pkg::IDX_PMM_LOW]};
  assign rx_descriptor_buffer_count_o = st.buf_count;
  assign irq_flags_o = {st.regs[erx_pkg::IDX_IRQ_REQ][erx_pkg::BIT_TX_BUS_ERR],
                        st.regs[erx_pkg::IDX_IRQ_REQ][erx_pkg::BIT_RX_BUS_ERR],
                        st.regs[erx_pkg::IDX_IRQ_REQ][erx_pkg::BIT_EMPTY_WM],
                        st.regs[erx_pkg::IDX_IRQ_REQ][erx_pkg::BIT_FULL_WM]};

  // Interrupt is high while any unmasked sticky event bit is set.
  assign irq_o = |(st.regs[erx_pkg::IDX_EVT_STAT][3:0] & st.regs[erx_pkg::IDX_EVT_MASK][3:0]);

endmodule

`default_nettype wire

// File: testbench/erx_irq_mask_props.sv
// Checker of bus stalls, interrupt flags, count and mask behaviour at the block's ports.
`timescale 1ns/1ps
`default_nettype none
module erx_irq_mask_props (
  input wire logic        ref_clk_i,                    // Clock.
  input wire logic        srst_i,                       // Reset.
  input wire logic        avs_read_i,                   // Read request.
  input wire logic        avs_write_i,                  // Write request.
  input wire logic        avs_waitrequest_o,            // Stall.
  input wire logic        tx_dma_bus_error_i,           // TX bus error.
  input wire logic        rx_dma_bus_error_i,           // RX bus error.
  input wire logic        rx_buffer_count_inc_i,        // Count increment.
  input wire logic [63:0] pattern_match_mask_o,         // Mask.
  input wire logic [7:0]  rx_descriptor_buffer_count_o, // Count.
  input wire logic [3:0]  irq_flags_o                   // Flags 14, 13, 9, 8.
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // A request that is still stalled by the block.
  sequence stall_s;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  // A cycle in which neither software nor hardware may move the count.
  sequence quiet_s;
    !avs_write_i && !rx_buffer_count_inc_i;
  endsequence
  // Bus answers after no more than one wait state.
  one_wait_a: assert property (stall_s |=> !avs_waitrequest_o)
    else $error("request stalled more than one cycle");
  // Bus-error flags set on the error and hold without a write.
  tx_set_a: assert property (tx_dma_bus_error_i |=> irq_flags_o[3])
    else $error("tx bus error flag not set");
  rx_set_a: assert property (rx_dma_bus_error_i |=> irq_flags_o[2])
    else $error("rx bus error flag not set");
  tx_hold_a: assert property (irq_flags_o[3] && !avs_write_i |=> irq_flags_o[3])
    else $error("tx bus error flag dropped");
  rx_hold_a: assert property (irq_flags_o[2] && !avs_write_i |=> irq_flags_o[2])
    else $error("rx bus error flag dropped");
  // Watermark flags fall only for their own causes; a fall made by reset is left out.
  empty_clr_a: assert property (rx_buffer_count_inc_i |=> !irq_flags_o[1])
    else $error("empty flag kept over increment");
  empty_why_a: assert property ($fell(irq_flags_o[1]) && !$past(srst_i)
                                |-> $past(rx_buffer_count_inc_i))
    else $error("empty flag fell without increment");
  full_why_a: assert property ($fell(irq_flags_o[0]) && !$past(srst_i)
                               |-> $past(avs_write_i))
    else $error("full flag fell without a write");
  count_keep_a: assert property (quiet_s |=> $stable(rx_descriptor_buffer_count_o))
    else $error("count moved without cause");
  mask_keep_a: assert property (!avs_write_i |=> $stable(pattern_match_mask_o))
    else $error("mask moved without a write");
endmodule
bind erx_irq_mask erx_irq_mask_props u_props (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .tx_dma_bus_error_i(tx_dma_bus_error_i), .rx_dma_bus_error_i(rx_dma_bus_error_i),
  .rx_buffer_count_inc_i(rx_buffer_count_inc_i), .pattern_match_mask_o(pattern_match_mask_o),
  .rx_descriptor_buffer_count_o(rx_descriptor_buffer_count_o), .irq_flags_o(irq_flags_o));
`default_nettype wire

// File: testbench/erx_dma_model.sv
// Model of the DMA and frame side that raises bus errors, increments and frame events.
`timescale 1ns/1ps
`default_nettype none
module erx_dma_model (
  input  wire logic       ref_clk_i,      // Clock.
  output logic            tx_bus_error_o, // TX bus error pulse.
  output logic            rx_bus_error_o, // RX bus error pulse.
  output logic            count_inc_o,    // Descriptor added.
  output logic [5:0]      stat_event_o    // Frame events.
);
  logic [8:0] ev = 9'h000;
  // Outputs mirror the event word; each pulse lasts one clock.
  assign {tx_bus_error_o, rx_bus_error_o, count_inc_o, stat_event_o} = ev;
  // Raises the given events for one cycle, changing only after a rising edge.
  task automatic pulse(input logic [8:0] v);
    @(posedge ref_clk_i);
    ev <= v;
    @(posedge ref_clk_i);
    ev <= 9'h000;
  endtask
endmodule
`default_nettype wire

// File: testbench/tb_erx_irq_mask.sv
// Self-checking bench of the register file, interrupt flags and pattern mask.
`timescale 1ns/1ps
`default_nettype none
module tb_erx_irq_mask;
  logic             clk   = 1'b0;
  logic             srst  = 1'b1;
  logic [13:0]      addr  = 14'h0000;
  logic             rd_en = 1'b0;
  logic             wr_en = 1'b0;
  logic [3:0]       be    = 4'hF;
  logic [31:0]      wdata = 32'h00000000;
  wire logic [31:0] rdata;
  wire logic        wreq, txe, rxe, inc, ren, irq;
  wire logic [5:0]  stat;
  wire logic [3:0]  mode, flags;
  wire logic [63:0] mask;
  wire logic [7:0]  cnt;
  int               n_errors = 0;
  int               check_count = 0;
  // Clock of 5 ns period.
  always #2.5 clk = ~clk;
  erx_irq_mask dut (
    .ref_clk_i(clk), .srst_i(srst), .avs_address_i(addr), .avs_read_i(rd_en),
    .avs_write_i(wr_en), .avs_byteenable_i(be), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .tx_dma_bus_error_i(txe),
    .rx_dma_bus_error_i(rxe), .rx_buffer_count_inc_i(inc), .stat_event_i(stat),
    .receive_enable_o(ren), .pattern_match_mode_o(mode), .pattern_match_mask_o(mask),
    .rx_descriptor_buffer_count_o(cnt), .irq_flags_o(flags), .irq_o(irq));
  erx_dma_model u_dma (.ref_clk_i(clk), .tx_bus_error_o(txe), .rx_bus_error_o(rxe),
    .count_inc_o(inc), .stat_event_o(stat));
  // ************************************************************
  // Reporting and bus tasks
  // ************************************************************
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [13:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    int i;
    @(posedge clk);
    addr <= a;
    wr_en <= w;
    rd_en <= !w;
    wdata <= d;
    be <= b;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (wreq !== 1'b0 && i < 20);
    q = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    if (wreq !== 1'b0) begin
      n_errors++;
      $display("ERROR at %0t: bus timeout", $time);
      stop_test();
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] b);
    logic [31:0] q;
    bus(1'b1, a, d, b, q);
  endtask
  task automatic rdc(input logic [13:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, 4'hF, q);
    chk(q, e);
  endtask
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  // Reset values of the configuration table, then counters before and after events.
  task automatic t_reset();
    logic [31:0] rv [11] = '{32'h0000800D, 32'h00004082, 32'h00000012, 32'h00000C12,
      32'h0000370F, 32'h000005EE, 32'h00001000, 32'h00000000, 32'h00000020,
      32'h00000000, 32'h00000100};
    for (int k = 0; k < 11; k++) begin
      rdc(14'h2200 + 14'(k * 16), rv[k]);
    end
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 6; k++) begin
        rdc(14'h2110 + 14'(k * 16), 32'(p * (2 - k % 2)));
      end
      u_dma.pulse(9'h03F);
      u_dma.pulse(9'h015);
    end
    rdc(14'h2030, 32'h00000000);
    rdc(14'h2040, 32'h00000000);
  endtask
  // Base, clear, set and invert views of one register, and refused places.
  task automatic t_alias();
    wr(14'h2200, 32'hFFFFFFFF, 4'hF);
    rdc(14'h2200, 32'h0000CF1F);
    wr(14'h2204, 32'h0000000F, 4'hF);
    rdc(14'h2200, 32'h0000CF10);
    wr(14'h2208, 32'h00000001, 4'hF);
    rdc(14'h2200, 32'h0000CF11);
    wr(14'h220C, 32'h00000101, 4'hF);
    rdc(14'h220C, 32'h0000CE10);
    wr(14'h3000, 32'hFFFFFFFF, 4'hF);
    rdc(14'h3000, 32'h00000000);
    rdc(14'h2084, 32'h00000000);
  endtask
  // Half-word lanes are written, a byte access is ignored.
  task automatic t_lanes();
    wr(14'h2030, 32'hAAAA5555, 4'h3);
    rdc(14'h2030, 32'h00005555);
    wr(14'h2030, 32'hAAAA5555, 4'hC);
    rdc(14'h2030, 32'hAAAA5555);
    wr(14'h2030, 32'h000000FF, 4'h1);
    rdc(14'h2030, 32'hAAAA5555);
    wr(14'h2040, 32'h12345678, 4'hF);
    settle();
    chk(mask[63:32], 32'h12345678);
    chk(mask[31:0], 32'hAAAA5555);
  endtask
  // Bus errors set sticky flags, raise the interrupt and clear through the clear view.
  task automatic t_buserr();
    logic [31:0] q;
    wr(14'h2070, 32'h00000003, 4'hF);
    bus(1'b0, 14'h2060, 32'h00000000, 4'hF, q);
    u_dma.pulse(9'h100);
    settle();
    chk(32'(flags[3]), 32'h00000001);
    chk(32'(irq), 32'h00000001);
    bus(1'b0, 14'h2060, 32'h00000000, 4'hF, q);
    chk(32'(q[1:0]), 32'h00000001);
    settle();
    chk(32'(irq), 32'h00000000);
    chk(32'(flags[3]), 32'h00000001);
    wr(14'h2054, 32'h00004000, 4'hF);
    settle();
    chk(32'(flags[3]), 32'h00000000);
    u_dma.pulse(9'h080);
    settle();
    rdc(14'h2050, 32'h00002300);
    wr(14'h2054, 32'h00002000, 4'hF);
    rdc(14'h2050, 32'h00000300);
    wr(14'h2070, 32'h00000000, 4'hF);
    u_dma.pulse(9'h100);
    settle();
    chk(32'(irq), 32'h00000000);
    wr(14'h2054, 32'h00004000, 4'hF);
  endtask
  // Watermark flags follow the count and ignore direct writes.
  task automatic t_wmark();
    wr(14'h2020, 32'h00030002, 4'hF);
    wr(14'h2058, 32'h00000300, 4'hF);
    wr(14'h2054, 32'h00000300, 4'hF);
    wr(14'h2050, 32'h00000000, 4'hF);
    settle();
    chk(32'(flags[1:0]), 32'h00000003);
    wr(14'h2000, 32'h00000001, 4'hF);
    settle();
    chk(32'(flags[1:0]), 32'h00000002);
    chk(32'(cnt), 32'h00000000);
    repeat (3) u_dma.pulse(9'h040);
    settle();
    chk(32'(cnt), 32'h00000003);
    chk(32'(flags[1:0]), 32'h00000001);
    wr(14'h2000, 32'h00000001, 4'hF);
    settle();
    chk(32'(cnt), 32'h00000002);
    chk(32'(flags[1:0]), 32'h00000002);
  endtask
  // Control outputs, and a mask change made only while the match mode is zero.
  task automatic t_ctrl();
    wr(14'h2000, 32'h00000100, 4'hF);
    wr(14'h2010, 32'h00000F00, 4'hF);
    settle();
    chk(32'(ren), 32'h00000001);
    chk(32'(mode), 32'h0000000F);
    wr(14'h2010, 32'h00000000, 4'hF);
    wr(14'h2030, 32'h00000011, 4'hF);
    rdc(14'h2030, 32'h00000011);
  endtask
  // Reset in mid-run clears bus-error flags, count and mask; watermark flags set again.
  task automatic t_rerst();
    u_dma.pulse(9'h180);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    settle();
    chk(32'(cnt), 32'h00000000);
    chk(32'(flags), 32'h00000003);
    rdc(14'h2060, 32'h0000000C);
    rdc(14'h2030, 32'h00000000);
  endtask
  // Main sequence.
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_alias();
    t_lanes();
    t_buserr();
    t_wmark();
    t_ctrl();
    t_rerst();
    stop_test();
  end
endmodule
`default_nettype wire
